// >>> common/adc_sched_pkg.sv
package adc_sched_pkg;
    // Register addresses on the special function register bus.
    localparam logic [7:0] ADDR_TEMP_RES = 8'hD7;
    localparam logic [7:0] ADDR_TRIGGER = 8'hD8;
    localparam logic [7:0] ADDR_CELL_RES = 8'hDF;
    localparam logic [7:0] ADDR_SUPPLY_RES = 8'hEF;
    localparam logic [7:0] ADDR_DELTA = 8'hF3;
    localparam logic [7:0] ADDR_INTERVAL = 8'hF9;
    localparam logic [7:0] ADDR_ALARM = 8'hFA;
    // Reset values.
    localparam logic [7:0] INTERVAL_RST = 8'h00;
    localparam logic [7:0] DELTA_RST = 8'h00;
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [7:0] ALARM_RST = 8'h00;
    // Field positions in the interval and delta registers.
    localparam int SUPPLY_IVL_LSB = 4;
    localparam int CELL_IVL_LSB = 2;
    localparam int TEMP_IVL_LSB = 0;
    localparam int THERMAL_THR_LSB = 3;
    localparam int SUPPLY_THR_LSB = 0;
    // Single request bits in the trigger register.
    localparam int CELL_REQ_BIT = 0;
    localparam int TEMP_REQ_BIT = 1;
    localparam int SUPPLY_REQ_BIT = 2;
    // Channel numbers, also the fixed issue order (lowest first).
    localparam logic [1:0] CH_TEMP = 2'h0;
    localparam logic [1:0] CH_CELL = 2'h1;
    localparam logic [1:0] CH_SUPPLY = 2'h2;
    // Background intervals in minutes for codes 01, 10 and 11.
    localparam logic [4:0] TEMP_MIN_C1 = 5'h08;
    localparam logic [4:0] TEMP_MIN_C2 = 5'h02;
    localparam logic [4:0] TEMP_MIN_C3 = 5'h01;
    localparam logic [4:0] CELL_MIN_C1 = 5'h10;
    localparam logic [4:0] CELL_MIN_C2 = 5'h04;
    localparam logic [4:0] CELL_MIN_C3 = 5'h01;
    localparam logic [4:0] SUPPLY_MIN_C1 = 5'h08;
    localparam logic [4:0] SUPPLY_MIN_C2 = 5'h02;
    localparam logic [4:0] SUPPLY_MIN_C3 = 5'h01;
    // Delta threshold codes with a special meaning.
    localparam logic [2:0] THR_OFF = 3'h0;
    localparam logic [2:0] THR_ALL = 3'h7;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_WAIT = 2'b10
    } conv_state_t;
endpackage

// >>> common/sched_if.sv
`timescale 1ns/1ps
interface sched_if;
    logic tick;
    logic [2:0][1:0] code;
    logic [2:0] due;
    modport timer (input tick, input code, output due);
    modport sched (output tick, output code, input due);
endinterface

// >>> hw/interval_timer.sv
`timescale 1ns/1ps
module interval_timer (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Scheduler side.
    sched_if.timer sif
);
    // Minutes between conversions for a channel and interval code.
    function automatic logic [4:0] period_of(input int ch, input logic [1:0] code);
        logic [4:0] p;
        p = 5'h01;
        case (ch)
            0: p = (code == 2'h1) ? adc_sched_pkg::TEMP_MIN_C1 :
                   (code == 2'h2) ? adc_sched_pkg::TEMP_MIN_C2 : adc_sched_pkg::TEMP_MIN_C3;
            1: p = (code == 2'h1) ? adc_sched_pkg::CELL_MIN_C1 :
                   (code == 2'h2) ? adc_sched_pkg::CELL_MIN_C2 : adc_sched_pkg::CELL_MIN_C3;
            default: p = (code == 2'h1) ? adc_sched_pkg::SUPPLY_MIN_C1 :
                   (code == 2'h2) ? adc_sched_pkg::SUPPLY_MIN_C2 : adc_sched_pkg::SUPPLY_MIN_C3;
        endcase
        return p;
    endfunction

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : chan_g
            logic [4:0] cnt_ff;
            logic [4:0] period;
            logic last_min;
            assign period = period_of(g, sif.code[g]);
            assign last_min = (cnt_ff + 5'h01) >= period;
            // Minutes elapsed; code 00 parks the counter so a later enable starts afresh.
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    cnt_ff <= 5'h00;
                else if (sif.code[g] == 2'h0)
                    cnt_ff <= 5'h00;
                else if (sif.tick)
                    cnt_ff <= last_min ? 5'h00 : cnt_ff + 5'h01;
            end
            // One due pulse on the tick that completes an interval.
            assign sif.due[g] = sif.tick && (sif.code[g] != 2'h0) && last_min;
            // A disabled channel never falls due.
            off_no_due_a: assert property (@(posedge clk) disable iff (!rstn)
                (sif.code[g] == 2'h0) |-> !sif.due[g])
                else $error("disabled channel fell due");
        end
    endgenerate
endmodule

// >>> hw/aux_adc_sched.sv
`timescale 1ns/1ps
// Overview of operation
// - Supply interval field 5:4: off, 8, 2 or 1 minutes.
// - Battery interval field 3:2: off, 16, 4 or 1 minutes.
// - Temperature interval field 1:0: off, 8, 2 or 1 minutes.
// - Temperature delta field 5:3 gives 1 to 6 LSB versus last interrupting result.
// - Temperature delta 000 interrupts only on a single request, 111 interrupts on every conversion.
// - Supply delta field 2:0 behaves the same way as temperature delta.
// - Background conversions keep running in battery and sleep modes.
// - Interval, delta and trigger registers sit at F9, F3, D8, read-write.
// - Result registers at D7, DF and EF, read-write.
// - Battery alarm level register at FA, read-write.
// - Change interrupt needs absolute difference strictly above threshold.
// - Single request bits clear once the converter accepts the request.
// - Battery result below alarm level raises an interrupt.
// - A result register loads only when its conversion interrupts.
module aux_adc_sched #(
    parameter int RES_W = 8
) (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RSTN,
    // Minute tick from the real-time clock, one cycle per minute.
    input wire logic MINUTE_TICK,
    // Special function register bus.
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    output logic [7:0] SFR_RDATA,
    // Shared converter.
    output logic CONV_REQ,
    output logic [1:0] CONV_SEL,
    input wire logic CONV_ACK,
    input wire logic CONV_DONE,
    input wire logic [RES_W-1:0] CONV_DATA,
    // Result interrupts, one-cycle pulses.
    output logic IRQ_TEMP,
    output logic IRQ_CELL,
    output logic IRQ_SUPPLY
);
    generate
        if (RES_W != 8)
        begin : width_check_g
            $error("aux_adc_sched serves only 8-bit results");
        end
    endgenerate

    // Absolute difference of two results.
    function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
        return (a > b) ? (a - b) : (b - a);
    endfunction

    logic [7:0] interval_ff;
    logic [7:0] delta_ff;
    logic [2:0] trig_ff;
    logic [7:0] temp_res_ff;
    logic [7:0] cell_res_ff;
    logic [7:0] supply_res_ff;
    logic [7:0] alarm_ff;
    logic [2:0] pend_ff;
    logic [1:0] chan_ff;
    logic single_ff;
    adc_sched_pkg::conv_state_t state_ff;
    logic [7:0] rdata_ff;
    logic [2:0] irq_ff;
    logic [2:0] want;
    logic [1:0] pick;
    logic accept;
    logic done;
    logic [2:0] thermal_thr;
    logic [2:0] supply_thr;
    logic temp_irq;
    logic cell_irq;
    logic supply_irq;
    logic [2:0] trig_pos;

    // Writes strobe on the bus.
    function automatic logic wr_at(input logic [7:0] a, input logic [7:0] sel, input logic wr);
        return wr && (a == sel);
    endfunction

    sched_if sif ();
    assign sif.tick = MINUTE_TICK;
    assign sif.code[0] = interval_ff[adc_sched_pkg::TEMP_IVL_LSB +: 2];
    assign sif.code[1] = interval_ff[adc_sched_pkg::CELL_IVL_LSB +: 2];
    assign sif.code[2] = interval_ff[adc_sched_pkg::SUPPLY_IVL_LSB +: 2];

    interval_timer u_timer (
        .clk(REF_CLK),
        .rstn(RSTN),
        .sif(sif)
    );

    // Configuration registers; bits 7:6 of the interval register are stored as written.
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            interval_ff <= adc_sched_pkg::INTERVAL_RST;
            delta_ff <= adc_sched_pkg::DELTA_RST;
            alarm_ff <= adc_sched_pkg::ALARM_RST;
        end
        else
        begin
            if (wr_at(SFR_ADDR, adc_sched_pkg::ADDR_INTERVAL, SFR_WR))
                interval_ff <= SFR_WDATA;
            if (wr_at(SFR_ADDR, adc_sched_pkg::ADDR_DELTA, SFR_WR))
                delta_ff <= {2'h0, SFR_WDATA[5:0]};
            if (wr_at(SFR_ADDR, adc_sched_pkg::ADDR_ALARM, SFR_WR))
                alarm_ff <= SFR_WDATA;
        end
    end

    // Trigger bits are kept in channel order: temp, battery, supply.
    assign trig_pos = {SFR_WDATA[adc_sched_pkg::SUPPLY_REQ_BIT],
                       SFR_WDATA[adc_sched_pkg::CELL_REQ_BIT],
                       SFR_WDATA[adc_sched_pkg::TEMP_REQ_BIT]};
    assign want = trig_ff | pend_ff;
    assign pick = want[0] ? adc_sched_pkg::CH_TEMP :
                  want[1] ? adc_sched_pkg::CH_CELL : adc_sched_pkg::CH_SUPPLY;
    assign accept = (state_ff == adc_sched_pkg::ST_REQ) && CONV_ACK;
    assign done = (state_ff == adc_sched_pkg::ST_WAIT) && CONV_DONE;

    // Single requests: software sets, acceptance clears, and a set in the same cycle wins.
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
            trig_ff <= 3'h0;
        else
        begin
            if (accept && single_ff)
                trig_ff[chan_ff] <= 1'h0;
            if (wr_at(SFR_ADDR, adc_sched_pkg::ADDR_TRIGGER, SFR_WR))
                trig_ff <= trig_pos | (trig_ff & ~(accept && single_ff ?
                           (3'h1 << chan_ff) : 3'h0));
        end
    end

    // Background work that fell due waits here; a new due pulse beats the clear.
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
            pend_ff <= 3'h0;
        else
            pend_ff <= (pend_ff & ~((accept && !single_ff) ? (3'h1 << chan_ff) : 3'h0))
                       | sif.due;
    end

    // Converter sequencing: one conversion in flight, held request until accepted.
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state_ff <= adc_sched_pkg::ST_IDLE;
            chan_ff <= adc_sched_pkg::CH_TEMP;
            single_ff <= 1'h0;
        end
        else
        begin
            case (state_ff)
                adc_sched_pkg::ST_IDLE:
                    if (want != 3'h0)
                    begin
                        state_ff <= adc_sched_pkg::ST_REQ;
                        chan_ff <= pick;
                        single_ff <= trig_ff[pick];
                    end
                adc_sched_pkg::ST_REQ:
                    if (CONV_ACK)
                        state_ff <= adc_sched_pkg::ST_WAIT;
                adc_sched_pkg::ST_WAIT:
                    if (CONV_DONE)
                        state_ff <= adc_sched_pkg::ST_IDLE;
                default:
                    state_ff <= adc_sched_pkg::ST_IDLE;
            endcase
        end
    end
    assign CONV_REQ = (state_ff == adc_sched_pkg::ST_REQ);
    assign CONV_SEL = chan_ff;

    // Interrupt decisions; a single request always interrupts.
    assign thermal_thr = delta_ff[adc_sched_pkg::THERMAL_THR_LSB +: 3];
    assign supply_thr = delta_ff[adc_sched_pkg::SUPPLY_THR_LSB +: 3];
    assign temp_irq = done && (chan_ff == adc_sched_pkg::CH_TEMP) && (single_ff
        || (thermal_thr == adc_sched_pkg::THR_ALL)
        || ((thermal_thr != adc_sched_pkg::THR_OFF)
            && (abs_diff(CONV_DATA, temp_res_ff) > {5'h00, thermal_thr})));
    assign supply_irq = done && (chan_ff == adc_sched_pkg::CH_SUPPLY) && (single_ff
        || (supply_thr == adc_sched_pkg::THR_ALL)
        || ((supply_thr != adc_sched_pkg::THR_OFF)
            && (abs_diff(CONV_DATA, supply_res_ff) > {5'h00, supply_thr})));
    assign cell_irq = done && (chan_ff == adc_sched_pkg::CH_CELL)
        && (single_ff || (CONV_DATA < alarm_ff));

    // Results load on an interrupting conversion, which beats a software write.
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            temp_res_ff <= adc_sched_pkg::RESULT_RST;
            cell_res_ff <= adc_sched_pkg::RESULT_RST;
            supply_res_ff <= adc_sched_pkg::RESULT_RST;
        end
        else
        begin
            if (temp_irq)
                temp_res_ff <= CONV_DATA;
            else if (wr_at(SFR_ADDR, adc_sched_pkg::ADDR_TEMP_RES, SFR_WR))
                temp_res_ff <= SFR_WDATA;
            if (cell_irq)
                cell_res_ff <= CONV_DATA;
            else if (wr_at(SFR_ADDR, adc_sched_pkg::ADDR_CELL_RES, SFR_WR))
                cell_res_ff <= SFR_WDATA;
            if (supply_irq)
                supply_res_ff <= CONV_DATA;
            else if (wr_at(SFR_ADDR, adc_sched_pkg::ADDR_SUPPLY_RES, SFR_WR))
                supply_res_ff <= SFR_WDATA;
        end
    end

    // Interrupt pulses, registered so they line up with the new result.
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
            irq_ff <= 3'h0;
        else
            irq_ff <= {supply_irq, cell_irq, temp_irq};
    end
    assign IRQ_TEMP = irq_ff[0];
    assign IRQ_CELL = irq_ff[1];
    assign IRQ_SUPPLY = irq_ff[2];

    // Read data is registered; unmapped addresses read zero.
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
            rdata_ff <= 8'h00;
        else if (SFR_RD)
        begin
            case (SFR_ADDR)
                adc_sched_pkg::ADDR_INTERVAL: rdata_ff <= interval_ff;
                adc_sched_pkg::ADDR_DELTA: rdata_ff <= delta_ff;
                adc_sched_pkg::ADDR_TRIGGER:
                    rdata_ff <= {5'h00, trig_ff[2], trig_ff[0], trig_ff[1]};
                adc_sched_pkg::ADDR_ALARM: rdata_ff <= alarm_ff;
                adc_sched_pkg::ADDR_TEMP_RES: rdata_ff <= temp_res_ff;
                adc_sched_pkg::ADDR_CELL_RES: rdata_ff <= cell_res_ff;
                adc_sched_pkg::ADDR_SUPPLY_RES: rdata_ff <= supply_res_ff;
                default: rdata_ff <= 8'h00;
            endcase
        end
    end
    assign SFR_RDATA = rdata_ff;

    req_hold_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        CONV_REQ && !CONV_ACK |=> CONV_REQ && $stable(CONV_SEL))
        else $error("request dropped before acceptance");
    trig_clear_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        accept && single_ff && !wr_at(SFR_ADDR, adc_sched_pkg::ADDR_TRIGGER, SFR_WR)
        |=> !trig_ff[$past(chan_ff)])
        else $error("single request not cleared on acceptance");
    temp_load_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        temp_irq |=> IRQ_TEMP && (temp_res_ff == $past(CONV_DATA)))
        else $error("temperature result not loaded with interrupt");
    result_hold_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        !supply_irq && !wr_at(SFR_ADDR, adc_sched_pkg::ADDR_SUPPLY_RES, SFR_WR)
        |=> $stable(supply_res_ff))
        else $error("supply result changed without interrupt");
    temp_off_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        done && !single_ff && (thermal_thr == adc_sched_pkg::THR_OFF) |=> !IRQ_TEMP)
        else $error("temperature interrupt while delta is off");
    strict_gt_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        done && !single_ff && (chan_ff == adc_sched_pkg::CH_SUPPLY)
        && (supply_thr != adc_sched_pkg::THR_ALL)
        && (abs_diff(CONV_DATA, supply_res_ff) <= {5'h00, supply_thr}) |=> !IRQ_SUPPLY)
        else $error("supply interrupt without exceeding delta");
    cell_alarm_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        done && (chan_ff == adc_sched_pkg::CH_CELL) && (CONV_DATA < alarm_ff)
        |=> IRQ_CELL ##1 !IRQ_CELL)
        else $error("low battery did not interrupt once");
    order_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (state_ff == adc_sched_pkg::ST_IDLE) && want[0] |=> CONV_REQ
        && (CONV_SEL == adc_sched_pkg::CH_TEMP))
        else $error("temperature not issued first");
endmodule

// >>> test/conv_model.sv
`timescale 1ns/1ps
// Shared converter stand-in: takes one request, acknowledges it, then returns a result.
module conv_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Request side.
    input wire logic req,
    input wire logic [1:0] sel,
    // Bench controls: slow answers and the value returned per channel.
    input wire logic slow,
    input wire logic [2:0][7:0] vals,
    // Answer side.
    output logic ack,
    output logic done,
    output logic [7:0] data
);
    logic busy;
    logic [3:0] cnt;
    logic [1:0] ch;
    wire [3:0] lat = slow ? 4'h9 : 4'h0;
    // Data flips every cycle outside a result, so a stale value can never pass for a new one.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            {ack, done, busy, cnt, ch, data} <= 17'h00000;
        end
        else
        begin
            ack <= 1'h0;
            done <= 1'h0;
            data <= ~data;
            if (busy || req)
            begin
                cnt <= cnt + 4'h1;
                if (cnt >= lat)
                begin
                    cnt <= 4'h0;
                    busy <= !busy;
                    ack <= !busy;
                    done <= busy;
                    ch <= busy ? ch : sel;
                    data <= busy ? vals[ch] : ~data;
                end
            end
        end
    end
endmodule

// >>> test/aux_adc_background_scheduler_tb.sv
`timescale 1ns/1ps
module aux_adc_background_scheduler_tb;
    logic ref_clk = 1'h0;
    logic rstn = 1'h0;
    logic minute_tick = 1'h0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'h0;
    logic sfr_rd = 1'h0;
    logic slow = 1'h0;
    logic [2:0][7:0] vals = '0;
    logic [7:0] sfr_rdata, conv_data, base;
    logic conv_req, conv_ack, conv_done, irq_temp, irq_cell, irq_supply;
    logic [1:0] conv_sel;
    logic [7:0] n_irq [3];
    logic [7:0] n_conv [3];
    logic [7:0] base_conv [3];
    logic [1:0] order_q [$];
    logic [2:0] code;
    logic hit;
    logic [7:0] dv, res;
    wire [2:0] irq_v = {irq_supply, irq_cell, irq_temp};
    int failures = 0;
    int n_compared = 0;
    int n_done = 0;
    int cycles = 0;
    // Register map, delta cases {code, data, result, irq} and interval cases.
    logic [7:0] map [7] = '{8'hD7, 8'hD8, 8'hDF, 8'hEF, 8'hF3, 8'hF9, 8'hFA};
    logic [7:0] ch_addr [2] = '{8'hD7, 8'hEF};
    logic [7:0] ch_ivl [2] = '{8'h03, 8'h30};
    int ch_sh [2] = '{3, 0};
    int ch_idx [2] = '{0, 2};
    logic [19:0] tcase [6] = '{{3'h3, 8'h43, 8'h40, 1'h0}, {3'h3, 8'h3C, 8'h3C, 1'h1},
        {3'h0, 8'h00, 8'h3C, 1'h0}, {3'h7, 8'h3D, 8'h3D, 1'h1}, {3'h6, 8'h44, 8'h44, 1'h1},
        {3'h1, 8'h45, 8'h44, 1'h0}};
    logic [16:0] bcase [3] = '{{8'h70, 8'h70, 1'h1}, {8'h90, 8'h70, 1'h0}, {8'h80, 8'h70, 1'h0}};
    logic [7:0] ivl_cfg [3] = '{8'h15, 8'h2A, 8'h3F};
    logic [23:0] ivl_exp [3] = '{{8'h02, 8'h01, 8'h02}, {8'h08, 8'h04, 8'h08},
        {8'h10, 8'h10, 8'h10}};

    // Free-running 250 MHz clock.
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    aux_adc_sched #(.RES_W(8)) dut (.REF_CLK(ref_clk), .RSTN(rstn), .MINUTE_TICK(minute_tick),
        .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata), .SFR_WR(sfr_wr), .SFR_RD(sfr_rd),
        .SFR_RDATA(sfr_rdata), .CONV_REQ(conv_req), .CONV_SEL(conv_sel), .CONV_ACK(conv_ack),
        .CONV_DONE(conv_done), .CONV_DATA(conv_data), .IRQ_TEMP(irq_temp),
        .IRQ_CELL(irq_cell), .IRQ_SUPPLY(irq_supply));
    conv_model conv (.clk(ref_clk), .rstn(rstn), .req(conv_req), .sel(conv_sel), .slow(slow),
        .vals(vals), .ack(conv_ack), .done(conv_done), .data(conv_data));

    // Counts interrupt pulses, accepted requests and their order, and completions.
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            give_verdict();
        end
        if (conv_done === 1'h1)
            n_done <= n_done + 1;
        for (int i = 0; i < 3; i++)
            if (!rstn)
                {n_irq[i], n_conv[i]} <= 16'h0000;
            else if (irq_v[i] === 1'h1)
                n_irq[i] <= n_irq[i] + 8'h01;
        if (conv_req === 1'h1 && conv_ack === 1'h1)
        begin
            n_conv[conv_sel] <= n_conv[conv_sel] + 8'h01;
            order_q.push_back(conv_sel);
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'h1;
        @(posedge ref_clk);
        sfr_wr <= 1'h0;
    endtask

    // Read data is registered, so it is taken just after the edge that follows the strobe.
    task automatic expect_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_rd <= 1'h1;
        @(posedge ref_clk);
        sfr_rd <= 1'h0;
        #1;
        check(what, exp, sfr_rdata);
    endtask

    task automatic pulse_tick();
        @(posedge ref_clk);
        minute_tick <= 1'h1;
        @(posedge ref_clk);
        minute_tick <= 1'h0;
    endtask

    // Waits for n completions under a bound, then leaves room for the interrupt pulse.
    task automatic settle(input int n);
        int start;
        int i;
        start = n_done;
        for (i = 0; i < 600 && n_done < start + n; i++)
            @(posedge ref_clk);
        repeat (8) @(posedge ref_clk);
        check("completions", 8'(start + n), 8'(n_done));
    endtask

    task automatic give_verdict();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'h1;
        // Reset values, then read-back of every writable place but the trigger register, and the unmapped address.
        for (int i = 0; i < 7; i++)
            expect_reg("reset value", map[i], 8'h00);
        sfr_write(8'h00, 8'h5A);
        expect_reg("unmapped", 8'h00, 8'h00);
        // The interval register is written with its top two bits at zero, as software must.
        for (int i = 0; i < 7; i++)
            if (i != 1)
                sfr_write(map[i], (8'hFF - 8'(i) * 8'h40) & (i == 5 ? 8'h3F : 8'hFF));
        for (int i = 0; i < 7; i++)
            if (i != 1)
            begin
                res = (i == 4 || i == 5) ? 8'h3F : 8'hFF - 8'(i) * 8'h40;
                expect_reg("read back", map[i], res);
            end
        sfr_write(8'hF9, 8'h00);
        sfr_write(8'hF3, 8'h00);
        // Three single requests at once, answered slowly.
        slow <= 1'h1;
        vals <= {8'h33, 8'h22, 8'h11};
        order_q.delete();
        sfr_write(8'hD8, 8'h07);
        expect_reg("trigger pending", 8'hD8, 8'h07);
        settle(3);
        expect_reg("trigger cleared", 8'hD8, 8'h00);
        check("issue order", {2'h0, order_q[0], order_q[1], order_q[2]}, 8'h06);
        for (int i = 0; i < 3; i++)
            check("single irq", 8'h01, n_irq[i]);
        for (int i = 0; i < 3; i++)
            expect_reg("single result", ch_addr[0] + 8'(i) * 8'h08 + (i == 2 ? 8'h08 : 8'h00),
                8'h11 * 8'(i + 1));
        slow <= 1'h0;
        // Change thresholds on temperature, then supply, each every minute.
        for (int c = 0; c < 2; c++)
        begin
            sfr_write(ch_addr[c], 8'h40);
            sfr_write(8'hF9, ch_ivl[c]);
            for (int k = 0; k < 6; k++)
            begin
                {code, dv, res, hit} = tcase[k];
                sfr_write(8'hF3, {5'h00, code} << ch_sh[c]);
                vals[ch_idx[c]] <= dv;
                base = n_irq[ch_idx[c]];
                pulse_tick();
                settle(1);
                check("change irq", base + {7'h00, hit}, n_irq[ch_idx[c]]);
                expect_reg("change result", ch_addr[c], res);
            end
            sfr_write(8'hF9, 8'h00);
        end
        // Battery alarm level against background battery results.
        sfr_write(8'hFA, 8'h80);
        sfr_write(8'hDF, 8'hC0);
        sfr_write(8'hF9, 8'h0C);
        for (int k = 0; k < 3; k++)
        begin
            {dv, res, hit} = bcase[k];
            vals[1] <= dv;
            base = n_irq[1];
            pulse_tick();
            settle(1);
            check("alarm irq", base + {7'h00, hit}, n_irq[1]);
            expect_reg("battery result", 8'hDF, res);
        end
        // Interval codes counted in minute ticks, all channels together.
        for (int j = 0; j < 3; j++)
        begin
            sfr_write(8'hF9, 8'h00);
            sfr_write(8'hF9, ivl_cfg[j]);
            base_conv = n_conv;
            order_q.delete();
            repeat (16)
            begin
                pulse_tick();
                repeat (30) @(posedge ref_clk);
            end
            for (int i = 0; i < 3; i++)
                check("conversions", ivl_exp[j][23 - 8 * i -: 8],
                    n_conv[i] - base_conv[i]);
        end
        check("tick order", {2'h0, order_q[0], order_q[1], order_q[2]}, 8'h06);
        give_verdict();
    end
endmodule
